// File: shared/ubr_pkg.sv
// package: constants, register map and types for the rate select and receiver recovery block
package ubr_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_TOGGLE   = 8'h08;
    localparam logic [7:0] ADDR_CMD      = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_TESTMODE = 8'h28;
    localparam logic [7:0] ADDR_TXDATA   = 8'h1c;

    // ctrl field positions
    localparam int CTRL_RX_SEL_LSB  = 0;
    localparam int CTRL_TX_SEL_LSB  = 4;
    localparam int CTRL_SET_BIT     = 8;
    localparam int CTRL_PARITY_LSB  = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // command codes
    localparam logic [3:0] CMD_RX_ENABLE = 4'h1;
    localparam logic [3:0] CMD_RX_RESET  = 4'h2;
    localparam logic [3:0] CMD_RX_DISABLE = 4'h3;

    // interrupt/status bit positions
    localparam int EV_RX_READY   = 0;
    localparam int EV_FRAME_ERR  = 1;
    localparam int EV_BREAK      = 2;
    localparam int EV_FALSE_START = 3;
    localparam int EV_WIDTH      = 4;

    localparam logic [1:0] PARITY_WAKEUP = 2'b11;
    localparam logic [3:0] SEL_TIMER = 4'hd;
    localparam logic [3:0] SEL_EXT16 = 4'he;
    localparam logic [3:0] SEL_EXT1  = 4'hf;

    // clock and rate arithmetic: 16x tick interval in clk cycles
    localparam int CLK_HZ = 40_000_000;

    // rate in tenths of a baud, indexed {test, set, code}
    function automatic int ubr_rate_x10(input logic test, input logic set, input logic [3:0] code);
        case ({test, set, code})
            6'h00: ubr_rate_x10 = 500;     6'h10: ubr_rate_x10 = 750;
            6'h01: ubr_rate_x10 = 1100;    6'h11: ubr_rate_x10 = 1100;
            6'h02: ubr_rate_x10 = 1345;    6'h12: ubr_rate_x10 = 384000;
            6'h03: ubr_rate_x10 = 2000;    6'h13: ubr_rate_x10 = 1500;
            6'h04: ubr_rate_x10 = 3000;    6'h14: ubr_rate_x10 = 3000;
            6'h05: ubr_rate_x10 = 6000;    6'h15: ubr_rate_x10 = 6000;
            6'h06: ubr_rate_x10 = 12000;   6'h16: ubr_rate_x10 = 12000;
            6'h07: ubr_rate_x10 = 10500;   6'h17: ubr_rate_x10 = 20000;
            6'h08: ubr_rate_x10 = 24000;   6'h18: ubr_rate_x10 = 24000;
            6'h09: ubr_rate_x10 = 48000;   6'h19: ubr_rate_x10 = 48000;
            6'h0a: ubr_rate_x10 = 72000;   6'h1a: ubr_rate_x10 = 18000;
            6'h0b: ubr_rate_x10 = 96000;   6'h1b: ubr_rate_x10 = 96000;
            6'h0c: ubr_rate_x10 = 384000;  6'h1c: ubr_rate_x10 = 192000;
            6'h20: ubr_rate_x10 = 48000;   6'h30: ubr_rate_x10 = 72000;
            6'h21: ubr_rate_x10 = 8800;    6'h31: ubr_rate_x10 = 8800;
            6'h22: ubr_rate_x10 = 10760;   6'h32: ubr_rate_x10 = 384000;
            6'h23: ubr_rate_x10 = 192000;  6'h33: ubr_rate_x10 = 144000;
            6'h24: ubr_rate_x10 = 288000;  6'h34: ubr_rate_x10 = 288000;
            6'h25: ubr_rate_x10 = 576000;  6'h35: ubr_rate_x10 = 576000;
            6'h26: ubr_rate_x10 = 1152000; 6'h36: ubr_rate_x10 = 1152000;
            6'h27: ubr_rate_x10 = 10500;   6'h37: ubr_rate_x10 = 20000;
            6'h28: ubr_rate_x10 = 576000;  6'h38: ubr_rate_x10 = 576000;
            6'h29: ubr_rate_x10 = 48000;   6'h39: ubr_rate_x10 = 48000;
            6'h2a: ubr_rate_x10 = 576000;  6'h3a: ubr_rate_x10 = 144000;
            6'h2b: ubr_rate_x10 = 96000;   6'h3b: ubr_rate_x10 = 96000;
            6'h2c: ubr_rate_x10 = 384000;  6'h3c: ubr_rate_x10 = 192000;
            default: ubr_rate_x10 = 96000;
        endcase
    endfunction

    // clk cycles per 16x tick, rounded down, at least one
    function automatic logic [15:0] ubr_div(input logic test, input logic set, input logic [3:0] code);
        int q;
        q = (CLK_HZ * 10) / (ubr_rate_x10(test, set, code) * 16);
        if (q < 1) begin
            q = 1;
        end
        ubr_div = q[15:0];
    endfunction

    typedef enum logic [2:0] {
        UBR_RX_IDLE  = 3'b000,
        UBR_RX_START = 3'b001,
        UBR_RX_DATA  = 3'b010,
        UBR_RX_STOP  = 3'b011,
        UBR_RX_STUCK = 3'b100
    } ubr_rx_state_e;
endpackage

// File: hw/ubr_tick_gen.sv
// one direction's rate generator: internal divider, timer or aux clock pin
`timescale 1ns/100ps
module ubr_tick_gen
    import ubr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       test_flag,
    input  wire logic       rate_set_bit,
    input  wire logic [3:0] rate_select_field,
    input  wire logic       force_1x,
    input  wire logic       timer_tick,
    input  wire logic       ext_rise,
    output logic            tick,
    output logic            one_x
);
    logic [15:0] cnt;
    logic [15:0] div;

    assign div = ubr_div(test_flag, rate_set_bit, rate_select_field);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else begin
            case (rate_select_field)
                SEL_TIMER: begin
                    tick <= timer_tick;
                    cnt  <= 16'h0000;
                end
                SEL_EXT16, SEL_EXT1: begin
                    tick <= ext_rise;
                    cnt  <= 16'h0000;
                end
                default: begin
                    // divider restarts whenever it passes the new limit so a rate change settles at once
                    if (cnt + 16'h0001 >= div) begin
                        cnt  <= 16'h0000;
                        tick <= 1'b1;
                    end else begin
                        cnt  <= cnt + 16'h0001;
                        tick <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            one_x <= 1'b0;
        end else begin
            one_x <= force_1x || (rate_select_field == SEL_EXT1);
        end
    end
endmodule

// File: hw/ubr_channel.sv
// one serial channel: axi4-lite registers, rate selection, filtered receiver with recovery, transmitter
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module ubr_channel
    import ubr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_pin,
    input  wire logic        aux_clock_pin,
    input  wire logic        timer_tick,
    output logic             tx_pin,
    output logic [7:0]       test_port,
    output logic             irq
);
    logic [31:0]   ctrl;
    logic          test_flag;
    logic          force_1x;
    logic [EV_WIDTH-1:0] irq_stat;
    logic [EV_WIDTH-1:0] irq_mask;
    logic [EV_WIDTH-1:0] ev;
    logic          rx_en;
    logic [7:0]    rx_data;
    logic [7:0]    tx_hold;
    logic          tx_full;
    logic          aw_hold;
    logic          w_hold;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic          wr_go;
    logic          rd_go;
    logic [31:0]   rd_val;
    logic          rd_ok;
    logic [1:0]    rx_sync;
    logic [1:0]    ax_sync;
    logic          ax_prev;
    logic          ax_rise;
    logic          ax_fall;
    logic [2:0]    filt_cnt;
    logic          rx_line;
    logic          rx_tick;
    logic          rx_1x;
    logic          tx_tick;
    logic          tx_1x;
    ubr_rx_state_e rx_state;
    logic [3:0]    rx_sub;
    logic [2:0]    rx_bit;
    logic [7:0]    rx_shift;
    logic [3:0]    tx_sub;
    logic [3:0]    tx_bit;
    logic [9:0]    tx_shift;
    logic          tx_busy;
    logic          tx_pend_fall;

    // pin inputs pass two flip-flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_sync <= 2'b11;
            ax_sync <= 2'b00;
            ax_prev <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[0], rx_pin};
            ax_sync <= {ax_sync[0], aux_clock_pin};
            ax_prev <= ax_sync[1];
        end
    end
    assign ax_rise = ax_sync[1] && !ax_prev;
    assign ax_fall = !ax_sync[1] && ax_prev;

    // run-length filter: line changes only after four agreeing samples in a row
    always_ff @(posedge clk) begin
        if (reset) begin
            filt_cnt <= 3'd0;
            rx_line  <= 1'b1;
        end else if (rx_sync[1] == rx_line) begin
            filt_cnt <= 3'd0;
        end else if (filt_cnt == 3'd3) begin
            filt_cnt <= 3'd0;
            rx_line  <= rx_sync[1];
        end else begin
            filt_cnt <= filt_cnt + 3'd1;
        end
    end

    // both directions share the one test flag but have their own select field
    ubr_tick_gen u_rx_rate (
        .clk               (clk),
        .reset             (reset),
        .test_flag         (test_flag),
        .rate_set_bit      (ctrl[CTRL_SET_BIT]),
        .rate_select_field (ctrl[CTRL_RX_SEL_LSB +: 4]),
        .force_1x          (force_1x),
        .timer_tick        (timer_tick),
        .ext_rise          (ax_rise),
        .tick              (rx_tick),
        .one_x             (rx_1x)
    );

    ubr_tick_gen u_tx_rate (
        .clk               (clk),
        .reset             (reset),
        .test_flag         (test_flag),
        .rate_set_bit      (ctrl[CTRL_SET_BIT]),
        .rate_select_field (ctrl[CTRL_TX_SEL_LSB +: 4]),
        .force_1x          (force_1x),
        .timer_tick        (timer_tick),
        .ext_rise          (ax_fall),
        .tick              (tx_tick),
        .one_x             (tx_1x)
    );

    // axi4-lite write: address and data taken in either order
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr <= ADDR_TXDATA || aw_addr == ADDR_TESTMODE) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read
    assign rd_go = s_axi_arvalid && s_axi_arready;
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_CTRL:     rd_val = ctrl;
            ADDR_STATUS:   rd_val = {25'h0, force_1x, test_flag, rx_state == UBR_RX_STUCK, tx_full, rx_en, irq_stat[1:0]};
            ADDR_TOGGLE:   rd_val = {31'h0, test_flag};
            ADDR_RXDATA:   rd_val = {24'h0, rx_data};
            ADDR_IRQ_STAT: rd_val = {28'h0, irq_stat};
            ADDR_IRQ_MASK: rd_val = {28'h0, irq_mask};
            ADDR_TESTMODE: rd_val = {31'h0, force_1x};
            ADDR_CMD, ADDR_TXDATA: rd_val = 32'h0000_0000;
            default:       rd_ok  = 1'b0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // test flag and forced 1x mode
    always_ff @(posedge clk) begin
        if (reset) begin
            test_flag <= 1'b0;
            force_1x  <= 1'b0;
        end else begin
            if (rd_go && s_axi_araddr == ADDR_TOGGLE) begin
                test_flag <= !test_flag;
            end
            if ((rd_go && s_axi_araddr == ADDR_TESTMODE) || (wr_go && aw_addr == ADDR_TESTMODE)) begin
                force_1x <= 1'b1;
            end
            if (wr_go && aw_addr == ADDR_TESTMODE && w_data[0] == 1'b0) begin
                force_1x <= 1'b0;
            end
        end
    end

    // configuration: receiver reset command never touches it
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl     <= CTRL_RESET;
            irq_mask <= '0;
        end else if (wr_go) begin
            if (aw_addr == ADDR_CTRL && s_axi_wstrb[1:0] == 2'b11) begin
                ctrl <= {20'h0, w_data[11:0]};
            end
            if (aw_addr == ADDR_IRQ_MASK && s_axi_wstrb[0]) begin
                irq_mask <= w_data[EV_WIDTH-1:0];
            end
        end
    end

    // sticky events: set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_go && aw_addr == ADDR_IRQ_STAT) ? w_data[EV_WIDTH-1:0] : '0)) | ev;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // receiver enable and commands
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_en <= 1'b0;
        end else if (wr_go && aw_addr == ADDR_CMD) begin
            if (w_data[3:0] == CMD_RX_ENABLE) begin
                rx_en <= 1'b1;
            end else if (w_data[3:0] == CMD_RX_RESET || w_data[3:0] == CMD_RX_DISABLE) begin
                rx_en <= 1'b0;
            end
        end
    end

    // receiver: 16 ticks per bit, or one tick per bit at 1x
    always_ff @(posedge clk) begin
        if (reset || (wr_go && aw_addr == ADDR_CMD && w_data[3:0] == CMD_RX_RESET)) begin
            rx_state <= UBR_RX_IDLE;
            rx_sub   <= 4'h0;
            rx_bit   <= 3'd0;
            rx_shift <= 8'h00;
            ev       <= '0;
            if (reset) begin
                rx_data <= 8'h00;
            end
        end else begin
            ev <= '0;
            if (rx_tick) begin
                case (rx_state)
                    UBR_RX_IDLE: begin
                        // in wake-up parity mode a start that fails is treated as lost sync
                        if (rx_en && !rx_line) begin
                            rx_state <= rx_1x ? UBR_RX_DATA : UBR_RX_START;
                            rx_sub   <= 4'h0;
                            rx_bit   <= 3'd0;
                        end
                    end
                    UBR_RX_START: begin
                        if (rx_line) begin
                            // noise before mid-bit is dropped; in wake-up mode it locks up
                            ev[EV_FALSE_START] <= 1'b1;
                            rx_state <= (ctrl[CTRL_PARITY_LSB +: 2] == PARITY_WAKEUP) ? UBR_RX_STUCK : UBR_RX_IDLE;
                        end else if (rx_sub == 4'h7) begin
                            rx_state <= UBR_RX_DATA;
                            rx_sub   <= 4'h0;
                        end else begin
                            rx_sub <= rx_sub + 4'h1;
                        end
                    end
                    UBR_RX_DATA: begin
                        if (rx_1x || rx_sub == 4'hf) begin
                            rx_sub   <= 4'h0;
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_bit   <= rx_bit + 3'd1;
                            if (rx_bit == 3'd7) begin
                                rx_state <= UBR_RX_STOP;
                            end
                        end else begin
                            rx_sub <= rx_sub + 4'h1;
                        end
                    end
                    UBR_RX_STOP: begin
                        if (rx_1x || rx_sub == 4'hf) begin
                            rx_state <= UBR_RX_IDLE;
                            rx_data  <= rx_shift;
                            ev[EV_RX_READY]  <= 1'b1;
                            ev[EV_FRAME_ERR] <= !rx_line;
                            ev[EV_BREAK]     <= !rx_line && rx_shift == 8'h00;
                        end else begin
                            rx_sub <= rx_sub + 4'h1;
                        end
                    end
                    UBR_RX_STUCK: begin
                        rx_state <= UBR_RX_STUCK;
                    end
                    default: begin
                        rx_state <= UBR_RX_IDLE;
                    end
                endcase
            end
        end
    end

    // transmitter: one start, eight data, one stop
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_hold  <= 8'h00;
            tx_full  <= 1'b0;
            tx_busy  <= 1'b0;
            tx_shift <= 10'h3ff;
            tx_sub   <= 4'h0;
            tx_bit   <= 4'h0;
            tx_pin   <= 1'b1;
            tx_pend_fall <= 1'b0;
        end else begin
            tx_pend_fall <= tx_tick;
            if (wr_go && aw_addr == ADDR_TXDATA && !tx_full) begin
                tx_hold <= w_data[7:0];
                tx_full <= 1'b1;
            end
            if (!tx_busy && tx_full) begin
                tx_busy  <= 1'b1;
                tx_full  <= 1'b0;
                tx_shift <= {1'b1, tx_hold, 1'b0};
                tx_sub   <= 4'h0;
                tx_bit   <= 4'h0;
            end else if (tx_busy && tx_pend_fall) begin
                // output moves one cycle after the falling edge is seen
                if (tx_1x || tx_sub == 4'hf) begin
                    tx_pin   <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_sub   <= 4'h0;
                    tx_bit   <= tx_bit + 4'h1;
                    if (tx_bit == 4'd10) begin
                        tx_busy <= 1'b0;
                    end
                end else begin
                    tx_sub <= tx_sub + 4'h1;
                end
            end
        end
    end

    // internal nodes on the test port only in forced 1x test mode
    always_ff @(posedge clk) begin
        if (reset) begin
            test_port <= 8'h00;
        end else begin
            test_port <= force_1x ? {rx_tick, tx_tick, rx_line, rx_state, rx_bit[1:0]} : 8'h00;
        end
    end
endmodule

// File: verification/ubr_checker.sv
// bus and pin assertions for one channel
`timescale 1ns/100ps
module ubr_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        tx_pin,
    input wire logic [7:0]  test_port,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_held;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    reset_state_a: assert property ($fell(reset) |-> tx_pin && !irq && test_port == 8'h00 && !s_axi_bvalid)
        else $error("outputs not idle after reset");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    rd_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_stands_a: assert property (wr_held |=> s_axi_bvalid)
        else $error("write response dropped");
    toggle_ok_a: assert property (rd_taken ##0 (s_axi_araddr == 8'h08) |=> s_axi_rresp == 2'b00)
        else $error("toggle read refused");
    bad_addr_a: assert property (rd_taken ##0 (s_axi_araddr == 8'h3c) |=> s_axi_rresp == 2'b10)
        else $error("unmapped read accepted");
endmodule
bind ubr_channel ubr_checker chk_u (.*);

// File: verification/ubr_peer.sv
// remote serial peer: framed characters and noise pulses on the receive line
`timescale 1ns/100ps
module ubr_peer #(
    parameter int BIT_CYCLES = 336
) (
    input  wire logic clk,
    output logic      rx_pin
);
    initial rx_pin = 1'b1;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
    endtask
    // the line idles high between pulses, as a pulled-up receive line would
    task automatic glitch(input int n);
        rx_pin <= 1'b0;
        repeat (n) @(posedge clk);
        rx_pin <= 1'b1;
    endtask
endmodule

// File: verification/testbench.sv
// channel bench: rate tables, receive, transmit, recovery and test address
`timescale 1ns/100ps
module testbench;
    import ubr_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, aux_clock_pin = 1'b0, timer_tick = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, test_port;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_pin, tx_pin, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          bad_count = 0, checks_done = 0, n;
    ubr_channel dut_u (.*);
    ubr_peer #(.BIT_CYCLES(336)) peer_u (.clk(clk), .rx_pin(rx_pin));
    always #12.5 clk = ~clk;
    // counter/timer stand-in: one pulse every four cycles
    logic [1:0]  tdiv = 2'b00;
    always @(posedge clk) begin
        tdiv       <= tdiv + 2'b01;
        timer_tick <= (tdiv == 2'b11);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            // ready trails valid by a cycle so the slave must hold its answer
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
        end while (!(s_axi_rvalid && s_axi_rready));
        v = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    // waits for the next start bit on the serial output and counts its length
    task automatic txw;
        n = 0;
        while (tx_pin && n < 2000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (!tx_pin && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, e, v & m);
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rc(ADDR_STATUS, 32'h20, 32'h0, "flag at reset");
        rc(ADDR_TOGGLE, 32'h1, 32'h0, "toggle one");
        rc(ADDR_TOGGLE, 32'h1, 32'h1, "toggle two");
        rc(ADDR_TOGGLE, 32'h1, 32'h0, "toggle three");
        rc(ADDR_STATUS, 32'h20, 32'h20, "flag set");
        wr(ADDR_CTRL, 32'h66);
        wr(ADDR_CMD, 32'(CMD_RX_ENABLE));
        wr(ADDR_IRQ_MASK, 32'h1);
        peer_u.glitch(2);
        repeat (400) @(posedge clk);
        rc(ADDR_IRQ_STAT, 32'h9, 32'h0, "noise taken");
        peer_u.send(8'ha5);
        chk("irq raised", 32'h1, 32'(irq));
        rc(ADDR_RXDATA, 32'hff, 32'ha5, "rx at test rate");
        rc(ADDR_IRQ_STAT, 32'h6, 32'h0, "no frame error");
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(ADDR_CMD, 32'(CMD_RX_RESET));
        rc(ADDR_CTRL, 32'h7ff, 32'h66, "ctrl kept");
        rc(ADDR_RXDATA, 32'hff, 32'ha5, "data kept");
        rc(ADDR_STATUS, 32'h4, 32'h0, "rx off");
        wr(ADDR_CMD, 32'(CMD_RX_ENABLE));
        rc(ADDR_STATUS, 32'h4, 32'h4, "rx on");
        wr(ADDR_CTRL, 32'h666);
        peer_u.glitch(60);
        repeat (200) @(posedge clk);
        rc(ADDR_STATUS, 32'h10, 32'h10, "stuck");
        wr(ADDR_CTRL, 32'h66);
        wr(ADDR_CMD, 32'(CMD_RX_RESET));
        wr(ADDR_CTRL, 32'h666);
        wr(ADDR_CMD, 32'(CMD_RX_ENABLE));
        rc(ADDR_STATUS, 32'h14, 32'h04, "recovered");
        wr(ADDR_CTRL, 32'h6b);
        wr(ADDR_TXDATA, 32'hff);
        txw;
        // the start bit is 16 ticks of 21 cycles; rx field would give 260 per tick
        chk("tx start width", 32'h1, 32'(n >= 334 && n <= 338));
        // all-ones data keeps the line high until the next frame's start bit
        wr(ADDR_CTRL, 32'hdb);
        wr(ADDR_TXDATA, 32'hff);
        txw;
        chk("tx timer start", 32'h1, 32'(n >= 62 && n <= 66));
        rd(8'h3c);
        chk("unmapped", 32'h2, 32'(resp));
        wr(8'h3c, 32'h0);
        chk("unmapped write", 32'h2, 32'(resp));
        rc(ADDR_TESTMODE, 32'hffff_fffe, 32'h0, "test address");
        rc(ADDR_STATUS, 32'h40, 32'h40, "forced 1x");
        chk("test port", 32'h20, 32'(test_port & 8'h20));
        wrap_up;
    end
endmodule
